// >>> design/watchdog_unit.v
`timescale 1ns/10ps
`include "hw_watchdog_defines.vh"

module watchdog_unit #(
    parameter AW = 12,
    parameter MC_DIV = `WDOG_MC_CYCLES,
    parameter PULSE_LEN = `WDOG_PULSE_CYCLES
) (
    input wire clock,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire power_down,
    input wire ext_int_n,
    output wire reset_pin
);

    localparam CB = `WDOG_COUNT_BITS;

    // Bus decode
    wire [AW-3:0] word_addr;
    wire aligned;
    wire hit_restart;
    wire hit_program;
    wire hit_status;
    wire hit_any;
    wire setup_phase;
    wire access_done;
    wire wr_done;
    wire [7:0] wbyte;

    assign word_addr = paddr[AW-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_restart = aligned &&
        (word_addr == {{(AW-10){1'b0}}, `WDOG_IDX_RESTART});
    assign hit_program = aligned &&
        (word_addr == {{(AW-10){1'b0}}, `WDOG_IDX_PROGRAM});
    assign hit_status = aligned &&
        (word_addr == {{(AW-10){1'b0}}, `WDOG_IDX_STATUS});
    assign hit_any = hit_restart || hit_program || hit_status;
    assign setup_phase = psel && !penable && !pready;
    assign access_done = psel && penable && pready;
    assign wr_done = access_done && pwrite && !pslverr;
    assign wbyte = pwdata[7:0];

    // Control state
    reg armed_q;
    reg armed_d;
    reg key_half_q;
    reg key_half_d;
    reg [2:0] sel_q;
    reg [2:0] sel_d;
    reg hold_q;
    reg hold_d;
    reg [3:0] mc_div_q;
    reg [3:0] mc_div_d;
    reg [CB-1:0] count_q;
    reg [CB-1:0] count_d;
    reg fire_q;
    reg fire_d;

    wire pulse_busy;
    wire mc_tick;
    wire count_en;
    wire restart_write;
    wire key_ok;
    wire [CB-1:0] limit;
    wire [CB-1:0] count_inc;
    wire [4:0] span;

    assign restart_write = wr_done && hit_restart;
    assign key_ok = restart_write && key_half_q && (wbyte == `WDOG_KEY_SECOND);
    assign mc_tick = (mc_div_q == MC_DIV[3:0] - 4'h1) && !power_down;
    assign count_en = armed_q && !hold_q && !power_down;
    assign count_inc = count_q + {{(CB-1){1'b0}}, 1'b1};
    assign span = 5'd14 + {2'h0, sel_q};

    // Limit mask: ones below bit 14+sel, i.e. 2^(14+sel)-1
    genvar gi;
    generate
        for (gi = 0; gi < CB; gi = gi + 1) begin : g_limit
            localparam [4:0] IDX = gi;
            assign limit[gi] = (IDX < span);
        end
    endgenerate

    // Machine-cycle divider; frozen while the oscillator is stopped
    always @* begin
        mc_div_d = mc_div_q;
        if (power_down) begin
            mc_div_d = mc_div_q;
        end else if (mc_tick) begin
            mc_div_d = 4'h0;
        end else begin
            mc_div_d = mc_div_q + 4'h1;
        end
    end

    // Power-down hold until the wake interrupt pin returns high
    always @* begin
        hold_d = hold_q;
        if (power_down) begin
            hold_d = 1'b1;
        end else if (ext_int_n) begin
            hold_d = 1'b0;
        end
    end

    // Key sequence tracking
    always @* begin
        key_half_d = key_half_q;
        if (restart_write) begin
            key_half_d = (wbyte == `WDOG_KEY_FIRST);
        end
        if (pulse_busy || fire_q) begin
            key_half_d = 1'b0;
        end
    end

    // Arming: never cleared by software
    always @* begin
        armed_d = armed_q;
        if (key_ok) begin
            armed_d = 1'b1;
        end
        if (pulse_busy || fire_q) begin
            armed_d = 1'b0;
        end
    end

    // Timeout select; reserved bits are not stored
    always @* begin
        sel_d = sel_q;
        if (wr_done && hit_program) begin
            sel_d = pwdata[`WDOG_SEL_MSB:`WDOG_SEL_LSB];
        end
        if (pulse_busy || fire_q) begin
            sel_d = `WDOG_SEL_RESET;
        end
    end

    // Counter and overflow
    always @* begin
        count_d = count_q;
        fire_d = 1'b0;
        if (key_ok) begin
            count_d = {CB{1'b0}};
        end else if (count_en && mc_tick) begin
            if (count_inc == limit) begin
                fire_d = 1'b1;
                count_d = {CB{1'b0}};
            end else begin
                count_d = count_inc;
            end
        end
        if (pulse_busy || fire_q) begin
            count_d = {CB{1'b0}};
            fire_d = 1'b0;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            armed_q <= 1'b0;
            key_half_q <= 1'b0;
            sel_q <= `WDOG_SEL_RESET;
            hold_q <= 1'b0;
            mc_div_q <= 4'h0;
            count_q <= {CB{1'b0}};
            fire_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            key_half_q <= key_half_d;
            sel_q <= sel_d;
            hold_q <= hold_d;
            mc_div_q <= mc_div_d;
            count_q <= count_d;
            fire_q <= fire_d;
        end
    end

    // APB slave: answer in the first access cycle
    reg [31:0] rdata_d;
    reg err_d;

    always @* begin
        rdata_d = 32'h0;
        err_d = !hit_any;
        if (hit_program) begin
            rdata_d[`WDOG_SEL_MSB:`WDOG_SEL_LSB] = sel_q;
        end
        if (hit_status) begin
            rdata_d[`WDOG_ST_ARMED] = armed_q;
            rdata_d[`WDOG_ST_KEY_HALF] = key_half_q;
            rdata_d[`WDOG_ST_HOLD] = hold_q;
            rdata_d[`WDOG_ST_PULSE] = pulse_busy;
            err_d = pwrite;
        end
        if (hit_restart && !pwrite) begin
            rdata_d = 32'h0;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0 : rdata_d;
            pready <= 1'b1;
            pslverr <= err_d;
        end else begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    reset_pulse_gen #(
        .LEN(PULSE_LEN),
        .CW(7)
    ) u_pulse (
        .clock(clock),
        .rstn(rstn),
        .fire(fire_q),
        .pulse_q(reset_pin)
    );

    assign pulse_busy = reset_pin;

endmodule

// >>> design/hw_watchdog_defines.vh
// Notes on behaviour
// - Inactive after any reset until armed
// - Arm by writing 1e then e1 to restart
// - Armed counter advances every machine cycle
// - Armed stays armed; only resets disarm
// - Default timeout overflow at 3fff resets device
// - Key sequence while armed clears the count
// - Restart write-only; counter not software visible
// - Overflow drives 96-period high reset pulse
// - Seven-stage prescaler lengthens the timeout
// - Select field sets 2^(14+sel)-1 cycle timeout
// - Reset clears select field to zero
// - Machine cycle is twelve oscillator periods
// - Stops in power-down; waits interrupt pin high
`ifndef HW_WATCHDOG_DEFINES_VH
`define HW_WATCHDOG_DEFINES_VH

// Register indices; byte address is four times the index
`define WDOG_IDX_RESTART 8'ha6
`define WDOG_IDX_PROGRAM 8'ha7
`define WDOG_IDX_STATUS 8'ha8

// Key bytes
`define WDOG_KEY_FIRST 8'h1e
`define WDOG_KEY_SECOND 8'he1

// Program register fields
`define WDOG_SEL_LSB 0
`define WDOG_SEL_MSB 2
`define WDOG_SEL_RESET 3'h0

// Status register fields
`define WDOG_ST_ARMED 0
`define WDOG_ST_KEY_HALF 1
`define WDOG_ST_HOLD 2
`define WDOG_ST_PULSE 3

// Counter structure
`define WDOG_BASE_BITS 14
`define WDOG_PRESCALE_BITS 7
`define WDOG_COUNT_BITS 21

// Timing: the clock is the oscillator, so one period per clock
`define WDOG_CLK_PER_TOSC 1
`define WDOG_MC_TOSC 12
`define WDOG_MC_CYCLES (`WDOG_MC_TOSC * `WDOG_CLK_PER_TOSC)
`define WDOG_PULSE_TOSC 96
`define WDOG_PULSE_CYCLES (`WDOG_PULSE_TOSC * `WDOG_CLK_PER_TOSC)

`endif

// >>> design/reset_pulse_gen.v
`timescale 1ns/10ps
`include "hw_watchdog_defines.vh"

module reset_pulse_gen #(
    parameter LEN = `WDOG_PULSE_CYCLES,
    parameter CW = 7
) (
    input wire clock,
    input wire rstn,
    input wire fire,
    output reg pulse_q
);

    reg [CW-1:0] left_q;
    reg [CW-1:0] left_d;
    reg pulse_d;

    always @* begin
        left_d = left_q;
        pulse_d = pulse_q;
        if (fire && !pulse_q) begin
            left_d = LEN[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
            pulse_d = 1'b1;
        end else if (pulse_q) begin
            if (left_q == {CW{1'b0}}) begin
                pulse_d = 1'b0;
            end else begin
                left_d = left_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            left_q <= {CW{1'b0}};
            pulse_q <= 1'b0;
        end else begin
            left_q <= left_d;
            pulse_q <= pulse_d;
        end
    end

endmodule

// >>> tb/watchdog_monitor.sv
`timescale 1ns/10ps
module watchdog_checker #(
    parameter PULSE_LEN = 96
) (
    input wire clock,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire reset_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Length of the current reset pulse
    reg [7:0] hi_q;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) hi_q <= 8'h00;
        else hi_q <= reset_pin ? hi_q + 8'h01 : 8'h00;
    end
    chk_pulse_width: assert property ($fell(reset_pin) |-> hi_q == 8'(PULSE_LEN))
        else $error("reset pulse width wrong");
    chk_no_repulse: assert property ($fell(reset_pin) |-> !reset_pin [*8])
        else $error("reset pulse restarted");
    chk_quiet_start: assert property ($rose(rstn) |-> !reset_pin && !pready)
        else $error("activity right after reset");
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_restart_unread: assert property (pready && !pwrite && paddr == 12'h298
        |-> prdata == 32'h0 && !pslverr)
        else $error("restart register readable");
    chk_prog_reserved: assert property (pready && !pwrite && paddr == 12'h29c
        |-> prdata[31:3] == 29'h0)
        else $error("program reserved bits set");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind watchdog_unit watchdog_checker #(.PULSE_LEN(PULSE_LEN)) watchdog_checker_inst (.clock,
    .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .reset_pin);

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam RS = 12'h298;
    localparam PR = 12'h29c;
    localparam ST = 12'h2a0;
    // Shortened machine cycle keeps the overflow run within budget
    localparam int MC = 2;
    localparam int TMO = 16383 * MC;
    localparam int PULSE = 96;
    logic clock, rstn, psel, penable, pwrite, power_down, ext_int_n;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, reset_pin;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int n_fail, checked, cyc, n;
    logic [31:0] sel_r;
    watchdog_unit #(.MC_DIV(MC)) watchdog_unit_inst (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down(power_down), .ext_int_n(ext_int_n),
        .reset_pin(reset_pin));
    always #2.5 clock = ~clock;
    task check_bus(input string nm, input logic [31:0] x, input logic [31:0] g);
        begin
            checked++;
            if (g !== x) begin
                n_fail++;
                $display("unexpected %s expected %h seen %h", nm, x, g);
            end
        end
    endtask
    task check_pin(input string nm, input logic x, input logic g);
        begin
            checked++;
            if (g !== x) begin
                n_fail++;
                $display("unexpected %s expected %b seen %b", nm, x, g);
            end
        end
    endtask
    task check_count(input string nm, input int lo, input int hi, input int g);
        begin
            checked++;
            if (g < lo || g > hi) begin
                n_fail++;
                $display("unexpected %s expected %0d to %0d seen %0d", nm, lo, hi, g);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checked %0d n_fail %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task apb(input bit w, input [11:0] a, input [7:0] d, input bit er, input [31:0] r);
        begin
            exp_q.push_back({w, er, r});
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'($urandom()), d};
            @(posedge clock);
            penable <= 1'b1;
            do @(posedge clock); while (pready !== 1'b1);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Checks each answer against the oldest note
    always @(posedge clock) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) check_bus("queue", 32'h1, 32'h0);
            else begin
                e = exp_q.pop_front();
                check_bus("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
                if (!e[33]) check_bus("prdata", e[31:0], prdata);
            end
        end
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        power_down = 1'b0;
        ext_int_n = 1'b1;
        void'($urandom(32'h170e));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        apb(0, ST, 8'h00, 0, 32'h0);
        apb(0, PR, 8'h00, 0, 32'h0);
        apb(1, PR, 8'h07, 0, 32'h0);
        apb(0, PR, 8'h00, 0, 32'h7);
        sel_r = $urandom() & 32'h7;
        apb(1, PR, sel_r[7:0], 0, 32'h0);
        apb(0, PR, 8'h00, 0, sel_r);
        apb(1, PR, 8'h00, 0, 32'h0);
        apb(0, RS, 8'h00, 0, 32'h0);
        apb(1, ST, 8'h01, 1, 32'h0);
        apb(0, 12'h000, 8'h00, 1, 32'h0);
        $display("test registers done");
        apb(1, RS, 8'h1e, 0, 32'h0);
        apb(1, RS, 8'h55, 0, 32'h0);
        apb(1, RS, 8'he1, 0, 32'h0);
        apb(0, ST, 8'h00, 0, 32'h0);
        apb(1, RS, 8'h1e, 0, 32'h0);
        apb(0, ST, 8'h00, 0, 32'h2);
        apb(1, RS, 8'he1, 0, 32'h0);
        apb(0, ST, 8'h00, 0, 32'h1);
        apb(1, RS, 8'h00, 0, 32'h0);
        apb(0, ST, 8'h00, 0, 32'h1);
        $display("test arming done");
        repeat (30000) @(posedge clock);
        check_pin("reset_pin", 1'b0, reset_pin);
        apb(1, RS, 8'h1e, 0, 32'h0);
        apb(1, RS, 8'he1, 0, 32'h0);
        n = 0;
        while (reset_pin !== 1'b1) begin
            @(posedge clock);
            n++;
        end
        check_count("timeout", TMO + 1, TMO + 2 * MC, n);
        n = 0;
        while (reset_pin === 1'b1) begin
            n++;
            @(posedge clock);
        end
        check_count("pulse", PULSE, PULSE, n);
        apb(0, ST, 8'h00, 0, 32'h0);
        apb(0, PR, 8'h00, 0, 32'h0);
        $display("test overflow done");
        apb(1, RS, 8'h1e, 0, 32'h0);
        apb(1, RS, 8'he1, 0, 32'h0);
        @(posedge clock);
        power_down <= 1'b1;
        apb(0, ST, 8'h00, 0, 32'h5);
        @(posedge clock);
        power_down <= 1'b0;
        ext_int_n <= 1'b0;
        apb(0, ST, 8'h00, 0, 32'h5);
        @(posedge clock);
        ext_int_n <= 1'b1;
        apb(0, ST, 8'h00, 0, 32'h1);
        $display("test power-down done");
        apb(1, PR, 8'h05, 0, 32'h0);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(0, ST, 8'h00, 0, 32'h0);
        apb(0, PR, 8'h00, 0, 32'h0);
        $display("test hardware reset done");
        complete_run;
    end
endmodule
